// *** logic/tmmf_params.svh ***
// constants for the timer mode and channel-a match flag block
`ifndef TMMF_PARAMS_SVH
`define TMMF_PARAMS_SVH

`define TMMF_DATA_W        8
`define TMMF_ADDR_W        3
`define TMMF_CNT_W         16
`define TMMF_NCH           3
`define TMMF_IRQ_W         3

`define TMMF_OFF_MODE      3'h0
`define TMMF_OFF_STAT_A    3'h1
`define TMMF_OFF_IRQ_STAT  3'h2
`define TMMF_OFF_IRQ_CLR   3'h3
`define TMMF_OFF_IRQ_EN    3'h4
`define TMMF_OFF_CNT_HI    3'h5
`define TMMF_OFF_CNT_LO    3'h6

`define TMMF_MODE_RST      8'h98
`define TMMF_MODE_FIXED    8'h98
`define TMMF_STAT_A_RST    8'h88
`define TMMF_STAT_A_FIXED  8'h88

`define TMMF_PHASE_BIT     6
`define TMMF_FLAG_DIRECTION_BIT      5
`define TMMF_PWM_LSB       0
`define TMMF_EN_LSB        4
`define TMMF_FLAG_LSB      0

`define TMMF_IRQ_OVF_BIT   0
`define TMMF_IRQ_FLAG_BIT  1
`define TMMF_IRQ_DIR_BIT   2

`define TMMF_CNT_MAX       16'hffff
`define TMMF_CNT_ZERO      16'h0000
`define TMMF_CNT_ONE       16'h0001
`define TMMF_BYTE_ZERO     8'h00

`endif

// *** logic/tmmf_pkg.sv ***
// types shared by the timer mode and match flag block
`include "tmmf_params.svh"

package tmmf_pkg;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`TMMF_ADDR_W-1:0] addr;
    logic [`TMMF_DATA_W-1:0] wdata;
  } tmmf_bus_req_type;

  typedef struct packed {
    logic [`TMMF_NCH-1:0] match_a;
    logic [`TMMF_NCH-1:0] match_b;
    logic [`TMMF_NCH-1:0] capture_a;
    logic [`TMMF_NCH-1:0] a_is_capture;
  } tmmf_chan_evt_type;

endpackage : tmmf_pkg

// *** logic/tmmf_phase_decoder.sv ***
// two-pin phase decoder producing registered count steps for channel 2
`timescale 1ns/100ps
`include "tmmf_params.svh"

module tmmf_phase_decoder (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // pins
  input  wire logic pin_a_i,
  input  wire logic pin_b_i,
  // steps
  output logic      step_o,
  output logic      up_o
);

  logic a_meta_reg;
  logic a_sync_reg;
  logic a_prev_reg;
  logic b_meta_reg;
  logic b_sync_reg;
  logic b_prev_reg;
  logic step_reg;
  logic up_reg;
  logic step_next;
  logic up_next;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      b_sync_reg <= 1'b0;
    end else if (ce_i) begin
      a_meta_reg <= pin_a_i;
      a_sync_reg <= a_meta_reg;
      b_meta_reg <= pin_b_i;
      b_sync_reg <= b_meta_reg;
    end
  end

  // both pins moving in one sample has no defined direction, so it is dropped
  always_comb begin
    step_next = (a_sync_reg ^ a_prev_reg) ^ (b_sync_reg ^ b_prev_reg);
    up_next   = a_prev_reg ^ b_sync_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      step_reg   <= 1'b0;
      up_reg     <= 1'b0;
    end else if (ce_i) begin
      a_prev_reg <= a_sync_reg;
      b_prev_reg <= b_sync_reg;
      step_reg   <= step_next;
      up_reg     <= up_next;
    end
  end

  assign step_o = step_reg;
  assign up_o   = up_reg;

  b_lead_up_a : assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !a_prev_reg && !a_sync_reg && !b_prev_reg && b_sync_reg) |=> (step_o && up_o))
    else $error("rising b with a low did not step up");

  a_lead_down_a : assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !a_prev_reg && a_sync_reg && !b_prev_reg && !b_sync_reg) |=> (step_o && !up_o))
    else $error("rising a with b low did not step down");

endmodule : tmmf_phase_decoder

// *** logic/tmmf_timer_core.sv ***
// timer mode register, channel-a match flags, channel 2 counter and pwm pins
`timescale 1ns/100ps
`include "tmmf_params.svh"

module tmmf_timer_core
  import tmmf_pkg::*;
(
  // clock, reset, enable, standby
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      standby_i,
  // register bus
  input  wire tmmf_bus_req_type          bus_req_i,
  output logic [`TMMF_DATA_W-1:0]        bus_rdata_o,
  // compare and capture events of channels 0 to 2
  input  wire tmmf_chan_evt_type         chan_evt_i,
  // channel 2 counting: start and clear in both modes, tick in normal mode
  input  wire logic                      start_ch2_i,
  input  wire logic                      count_tick_ch2_i,
  input  wire logic                      clear_ch2_i,
  // external clock pins
  input  wire logic                      ext_clock_pin_a_i,
  input  wire logic                      ext_clock_pin_b_i,
  // dma service of channel requests
  input  wire logic [`TMMF_NCH-1:0]      dma_ack_i,
  output logic [`TMMF_NCH-1:0]           match_a_request_o,
  // compare pins a
  output logic [`TMMF_NCH-1:0]           compare_pin_a_o,
  output logic [`TMMF_NCH-1:0]           compare_pin_a_oe_o,
  // channel 2 counter state
  output logic [`TMMF_CNT_W-1:0]         counter_ch2_o,
  output logic                           overflow_flag_set_o,
  // interrupt
  output logic                           irq_o
);

  function automatic logic hit(input logic strobe,
                               input logic [`TMMF_ADDR_W-1:0] addr,
                               input logic [`TMMF_ADDR_W-1:0] off);
    hit = strobe && (addr == off);
  endfunction : hit

  logic [`TMMF_DATA_W-1:0] mode_reg;
  logic [`TMMF_NCH-1:0]    irq_en_a_reg;
  logic [`TMMF_NCH-1:0]    flag_a_reg;
  logic [`TMMF_NCH-1:0]    flag_a_next;
  logic [`TMMF_NCH-1:0]    armed_reg;
  logic [`TMMF_NCH-1:0]    flag_set;
  logic [`TMMF_NCH-1:0]    sw_clear;
  logic [`TMMF_CNT_W-1:0]  counter_reg;
  logic [`TMMF_CNT_W-1:0]  counter_next;
  logic [`TMMF_DATA_W-1:0] rdata_reg;
  logic [`TMMF_DATA_W-1:0] rdata_next;
  logic [`TMMF_DATA_W-1:0] stat_a_view;
  logic [`TMMF_NCH-1:0]    pin_reg;
  logic [`TMMF_IRQ_W-1:0]  irq_stat_reg;
  logic [`TMMF_IRQ_W-1:0]  irq_en_reg;
  logic [`TMMF_IRQ_W-1:0]  irq_event;
  logic                    last_up_reg;
  logic                    ovf_set_reg;
  logic                    phase_mode;
  logic                    flag_dir;
  logic [`TMMF_NCH-1:0]    pwm_mode;
  logic                    step;
  logic                    step_up;
  logic                    inc;
  logic                    dec;
  logic                    overflow;
  logic                    underflow;
  logic                    wr_mode;
  logic                    wr_stat;
  logic                    rd_stat;
  logic                    wr_cnt_hi;
  logic                    wr_cnt_lo;
  logic                    init;

  // standby forces the same initial state as reset
  assign init       = !rst_n_i || standby_i;
  assign phase_mode = mode_reg[`TMMF_PHASE_BIT];
  assign flag_dir   = mode_reg[`TMMF_FLAG_DIRECTION_BIT];
  assign pwm_mode   = mode_reg[`TMMF_PWM_LSB +: `TMMF_NCH];

  assign wr_mode   = hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_MODE);
  assign wr_stat   = hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_STAT_A);
  assign rd_stat   = hit(bus_req_i.rd, bus_req_i.addr, `TMMF_OFF_STAT_A);
  assign wr_cnt_hi = hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_CNT_HI);
  assign wr_cnt_lo = hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_CNT_LO);

  tmmf_phase_decoder u_phase (
    .clk_i   (clk_i),
    .rst_n_i (!init),
    .ce_i    (ce_i),
    .pin_a_i (ext_clock_pin_a_i),
    .pin_b_i (ext_clock_pin_b_i),
    .step_o  (step),
    .up_o    (step_up)
  );

  // mode register; fixed bits are forced so writes cannot move them
  always_ff @(posedge clk_i) begin
    if (init) begin
      mode_reg <= `TMMF_MODE_RST;
    end else if (ce_i && wr_mode) begin
      mode_reg <= bus_req_i.wdata | `TMMF_MODE_FIXED;
    end
  end

  // channel 2 counter source: phase decoder in phase mode, the normal tick otherwise
  always_comb begin
    if (phase_mode) begin
      inc = start_ch2_i && step && step_up;
      dec = start_ch2_i && step && !step_up;
    end else begin
      inc = start_ch2_i && count_tick_ch2_i;
      dec = 1'b0;
    end
    overflow  = inc && (counter_reg == `TMMF_CNT_MAX);
    underflow = dec && (counter_reg == `TMMF_CNT_ZERO);
  end

  always_comb begin
    counter_next = counter_reg;
    if (clear_ch2_i) begin
      counter_next = `TMMF_CNT_ZERO;
    end else if (wr_cnt_hi) begin
      counter_next = {bus_req_i.wdata, counter_reg[`TMMF_DATA_W-1:0]};
    end else if (wr_cnt_lo) begin
      counter_next = {counter_reg[`TMMF_CNT_W-1:`TMMF_DATA_W], bus_req_i.wdata};
    end else if (inc) begin
      counter_next = counter_reg + `TMMF_CNT_ONE;
    end else if (dec) begin
      counter_next = counter_reg - `TMMF_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      counter_reg <= `TMMF_CNT_ZERO;
      ovf_set_reg <= 1'b0;
      last_up_reg <= 1'b1;
    end else if (ce_i) begin
      counter_reg <= counter_next;
      // the overflow flag itself sits in another register; we hand it the set pulse
      ovf_set_reg <= overflow || (underflow && !flag_dir);
      if (phase_mode && step) begin
        last_up_reg <= step_up;
      end
    end
  end

  assign counter_ch2_o       = counter_reg;
  assign overflow_flag_set_o = ovf_set_reg;

  // channel a flags: set wins over both clears
  always_comb begin
    for (int ch = 0; ch < `TMMF_NCH; ch++) begin
      flag_set[ch] = chan_evt_i.a_is_capture[ch] ? chan_evt_i.capture_a[ch]
                                                 : chan_evt_i.match_a[ch];
    end
    sw_clear    = armed_reg & ~bus_req_i.wdata[`TMMF_FLAG_LSB +: `TMMF_NCH]
                  & {`TMMF_NCH{wr_stat}};
    flag_a_next = flag_set | (flag_a_reg & ~(sw_clear | dma_ack_i));
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      flag_a_reg   <= '0;
      irq_en_a_reg <= '0;
    end else if (ce_i) begin
      flag_a_reg <= flag_a_next;
      if (wr_stat) begin
        irq_en_a_reg <= bus_req_i.wdata[`TMMF_EN_LSB +: `TMMF_NCH];
      end
    end
  end

  // a read arms only the flags seen at one; any later write of the register disarms
  always_ff @(posedge clk_i) begin
    if (init) begin
      armed_reg <= '0;
    end else if (ce_i) begin
      if (rd_stat) begin
        armed_reg <= flag_a_reg;
      end else if (wr_stat) begin
        armed_reg <= '0;
      end
    end
  end

  assign match_a_request_o = flag_a_reg & irq_en_a_reg;

  // pwm pins; with both matches in one cycle match a wins
  always_ff @(posedge clk_i) begin
    if (init) begin
      pin_reg <= '0;
    end else if (ce_i) begin
      for (int ch = 0; ch < `TMMF_NCH; ch++) begin
        if (!pwm_mode[ch]) begin
          pin_reg[ch] <= 1'b0;
        end else if (chan_evt_i.match_a[ch]) begin
          pin_reg[ch] <= 1'b1;
        end else if (chan_evt_i.match_b[ch]) begin
          pin_reg[ch] <= 1'b0;
        end
      end
    end
  end

  assign compare_pin_a_o    = pin_reg;
  assign compare_pin_a_oe_o = pwm_mode;

  // block interrupt: sticky events, write-one clear, enable mask
  always_comb begin
    irq_event                     = '0;
    irq_event[`TMMF_IRQ_OVF_BIT]  = overflow || (underflow && !flag_dir);
    irq_event[`TMMF_IRQ_FLAG_BIT] = |flag_set;
    irq_event[`TMMF_IRQ_DIR_BIT]  = phase_mode && step && (step_up != last_up_reg);
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
    end else if (ce_i) begin
      if (hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_IRQ_CLR)) begin
        irq_stat_reg <= irq_event
                        | (irq_stat_reg & ~bus_req_i.wdata[`TMMF_IRQ_W-1:0]);
      end else begin
        irq_stat_reg <= irq_event | irq_stat_reg;
      end
      if (hit(bus_req_i.wr, bus_req_i.addr, `TMMF_OFF_IRQ_EN)) begin
        irq_en_reg <= bus_req_i.wdata[`TMMF_IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // read path; unmapped and write-only offsets read as zero
  always_comb begin
    stat_a_view = `TMMF_STAT_A_FIXED;
    stat_a_view[`TMMF_EN_LSB +: `TMMF_NCH]   = irq_en_a_reg;
    stat_a_view[`TMMF_FLAG_LSB +: `TMMF_NCH] = flag_a_reg;
    rdata_next = `TMMF_BYTE_ZERO;
    case (bus_req_i.addr)
      `TMMF_OFF_MODE: begin
        rdata_next = mode_reg | `TMMF_MODE_FIXED;
      end
      `TMMF_OFF_STAT_A: begin
        rdata_next = stat_a_view;
      end
      `TMMF_OFF_IRQ_STAT: begin
        rdata_next[`TMMF_IRQ_W-1:0] = irq_stat_reg;
      end
      `TMMF_OFF_IRQ_EN: begin
        rdata_next[`TMMF_IRQ_W-1:0] = irq_en_reg;
      end
      `TMMF_OFF_CNT_HI: begin
        rdata_next = counter_reg[`TMMF_CNT_W-1:`TMMF_DATA_W];
      end
      `TMMF_OFF_CNT_LO: begin
        rdata_next = counter_reg[`TMMF_DATA_W-1:0];
      end
      default: begin
        rdata_next = `TMMF_BYTE_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      rdata_reg <= `TMMF_BYTE_ZERO;
    end else if (ce_i) begin
      rdata_reg <= bus_req_i.rd ? rdata_next : `TMMF_BYTE_ZERO;
    end
  end

  assign bus_rdata_o = rdata_reg;

  mode_init_a : assert property (
    @(posedge clk_i)
    (rst_n_i && standby_i) |=> (mode_reg == `TMMF_MODE_RST))
    else $error("mode register not initialised by standby");

  stat_init_a : assert property (
    @(posedge clk_i)
    (!rst_n_i || standby_i) |=> (flag_a_reg == '0 && irq_en_a_reg == '0))
    else $error("status a not initialised");

  mode_fixed_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && bus_req_i.rd && bus_req_i.addr == `TMMF_OFF_MODE)
      |=> ((bus_rdata_o & `TMMF_MODE_FIXED) == `TMMF_MODE_FIXED))
    else $error("mode fixed bits did not read as one");

  up_count_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && phase_mode && start_ch2_i && step && step_up && !clear_ch2_i
      && !wr_cnt_hi && !wr_cnt_lo)
      |=> (counter_reg == `TMMF_CNT_W'($past(counter_reg) + `TMMF_CNT_ONE)))
    else $error("phase step up did not increment counter");

  tick_ignored_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && phase_mode && !step && count_tick_ch2_i && !clear_ch2_i
      && !wr_cnt_hi && !wr_cnt_lo) |=> $stable(counter_reg))
    else $error("prescaler tick moved counter in phase mode");

  ovf_dir_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && underflow) |=> (overflow_flag_set_o == !$past(flag_dir)))
    else $error("underflow flag set disagrees with direction bit");

  ovf_wrap_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && overflow && !clear_ch2_i && !wr_cnt_hi && !wr_cnt_lo)
      |=> (counter_reg == `TMMF_CNT_ZERO && overflow_flag_set_o))
    else $error("overflow did not wrap and flag");

  clear_phase_a : assert property (
    @(posedge clk_i) disable iff (init)
    (ce_i && phase_mode && clear_ch2_i) |=> (counter_reg == `TMMF_CNT_ZERO))
    else $error("clear ignored in phase mode");

  for (genvar g = 0; g < `TMMF_NCH; g++) begin : g_chk
    flag_set_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && flag_set[g]) |=> (flag_a_reg[g] ##1 (flag_a_reg[g] || !$past(ce_i)
        || $past(dma_ack_i[g]) || $past(wr_stat))))
      else $error("match or capture event did not set flag");

    req_follow_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && flag_set[g] && irq_en_a_reg[g] && !wr_stat) |=> match_a_request_o[g])
      else $error("enabled flag set did not raise request");

    write_one_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && flag_a_reg[g] && wr_stat && bus_req_i.wdata[g] && !dma_ack_i[g])
        |=> flag_a_reg[g])
      else $error("writing one cleared a flag");

    read_clear_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && rd_stat && flag_a_reg[g] && !flag_set[g])
        ##1 (ce_i && wr_stat && !bus_req_i.wdata[g] && !flag_set[g]) |=> !flag_a_reg[g])
      else $error("read then write zero did not clear flag");

    noread_keep_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && flag_a_reg[g] && !armed_reg[g] && !dma_ack_i[g]) |=> flag_a_reg[g])
      else $error("flag cleared without prior read");

    dma_clear_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && dma_ack_i[g] && !flag_set[g]) |=> !flag_a_reg[g])
      else $error("dma service did not clear flag");

    pwm_high_a : assert property (
      @(posedge clk_i) disable iff (init)
      (ce_i && pwm_mode[g] && chan_evt_i.match_a[g] && !wr_mode)
        |=> (compare_pin_a_o[g] && compare_pin_a_oe_o[g]))
      else $error("pwm pin not high after match a");
  end

endmodule : tmmf_timer_core

// *** tb/tmmf_dma_model.sv ***
// dma controller model that services channel requests after a set latency
`timescale 1ns/100ps

module tmmf_dma_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // service control
  input  wire logic       en_i,
  input  wire logic [3:0] lat_i,
  // request and acknowledge
  input  wire logic [2:0] req_i,
  output logic      [2:0] ack_o
);
  logic [3:0] wait_reg;

  // one channel at a time, lowest first; the gap after an ack lets the request fall
  always_ff @(posedge clk_i) begin
    ack_o <= 3'h0;
    if (!rst_n_i || !en_i) begin
      wait_reg <= 4'h0;
    end else if (ack_o != 3'h0) begin
      wait_reg <= 4'h0;
    end else if (req_i != 3'h0) begin
      if (wait_reg == lat_i) begin
        ack_o    <= req_i & (~req_i + 3'h1);
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : tmmf_dma_model

// *** tb/tb_top.sv ***
// self-checking bench for the timer mode and match flag block
`timescale 1ns/100ps
`include "tmmf_params.svh"

module tb_top import tmmf_pkg::*; ();
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } tmmf_tb_row_type;

  logic              clk_i, rst_n_i, ce_i, standby_i;
  tmmf_bus_req_type  bus_req;
  tmmf_chan_evt_type evt;
  logic [7:0]        rdata;
  logic              start_ch2, tick, clr, pin_a, pin_b, dma_en, ovf_set, irq;
  logic [3:0]        lat;
  logic [2:0]        ack, req, pin, pin_oe;
  logic [15:0]       cnt, v;
  int                err_total, checks_done, ovf_cnt;
  logic [1:0]        up_seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  logic [1:0]        dn_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  tmmf_tb_row_type   rows [9] = '{
    '{3'h0, 8'h00, 8'h98}, '{3'h0, 8'h67, 8'hff}, '{3'h0, 8'h00, 8'h98},
    '{3'h1, 8'h77, 8'hf8}, '{3'h1, 8'h00, 8'h88}, '{3'h7, 8'h5a, 8'h00},
    '{3'h3, 8'hff, 8'h00}, '{3'h4, 8'h07, 8'h07}, '{3'h4, 8'h00, 8'h00}};

  tmmf_timer_core tmmf_timer_core_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .standby_i(standby_i),
    .bus_req_i(bus_req), .bus_rdata_o(rdata), .chan_evt_i(evt),
    .start_ch2_i(start_ch2), .count_tick_ch2_i(tick), .clear_ch2_i(clr),
    .ext_clock_pin_a_i(pin_a), .ext_clock_pin_b_i(pin_b), .dma_ack_i(ack),
    .match_a_request_o(req), .compare_pin_a_o(pin), .compare_pin_a_oe_o(pin_oe),
    .counter_ch2_o(cnt), .overflow_flag_set_o(ovf_set), .irq_o(irq));

  tmmf_dma_model tmmf_dma_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(dma_en), .lat_i(lat),
    .req_i(req), .ack_o(ack));

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_req <= '0;
    #1;
  endtask : wr

  task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus_req <= '0;
    #1;
    chk(n, rdata, e);
  endtask : rchk

  // status a read followed by a write in the very next cycle
  task automatic rwchk(input string n, input logic [7:0] e, input logic [7:0] d);
    @(posedge clk_i);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: 3'h1, wdata: 8'h00};
    @(posedge clk_i);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: 3'h1, wdata: d};
    #1;
    chk(n, rdata, e);
    @(posedge clk_i);
    bus_req <= '0;
    #1;
  endtask : rwchk

  task automatic ev(input logic [2:0] ma, input logic [2:0] mb, input logic [2:0] ca);
    @(posedge clk_i);
    evt.match_a   <= ma;
    evt.match_b   <= mb;
    evt.capture_a <= ca;
    @(posedge clk_i);
    evt.match_a   <= 3'h0;
    evt.match_b   <= 3'h0;
    evt.capture_a <= 3'h0;
    @(posedge clk_i);
    #1;
  endtask : ev

  // pins pass a two-flop synchroniser, so each level is held well past it
  task automatic ph(input logic [1:0] ab);
    @(posedge clk_i);
    {pin_a, pin_b} <= ab;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : ph

  task automatic summarize();
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_i) begin
    if (ovf_set === 1'b1) begin
      ovf_cnt++;
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    #(20 * 20000);
    err_total++;
    summarize();
  end

  initial begin
    {rst_n_i, standby_i, start_ch2, tick, clr, pin_a, pin_b, dma_en} = '0;
    ce_i = 1'b1;
    bus_req = '0;
    evt = '0;
    lat = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk("mode rst", 3'h0, 8'h98);
    rchk("stat rst", 3'h1, 8'h88);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk("row", rows[i].a, rows[i].e);
    end
    // match flags per channel, cleared by read then zero
    wr(3'h1, 8'h70);
    for (int c = 0; c < 3; c++) begin
      ev(3'h1 << c, 3'h0, 3'h0);
      chk("req", req, 3'h1 << c);
      rwchk("flag", 8'hf8 | (8'h1 << c), 8'h70);
      chk("req clr", req, 3'h0);
    end
    @(posedge clk_i);
    evt.a_is_capture <= 3'h7;
    ev(3'h7, 3'h0, 3'h0);
    rchk("cap ign", 3'h1, 8'hf8);
    ev(3'h0, 3'h0, 3'h5);
    rchk("cap", 3'h1, 8'hfd);
    // flag 1 arrives after the read, so this write leaves it standing
    ev(3'h0, 3'h0, 3'h2);
    wr(3'h1, 8'h70);
    rchk("unarmed", 3'h1, 8'hfa);
    wr(3'h1, 8'h77);
    rchk("one kept", 3'h1, 8'hfa);
    wr(3'h1, 8'h70);
    rchk("armed", 3'h1, 8'hf8);
    // enable gating, then dma service at prompt and slow latency
    for (int l = 0; l < 8; l += 7) begin
      wr(3'h1, 8'h00);
      ev(3'h0, 3'h0, 3'h7);
      chk("req off", req, 3'h0);
      wr(3'h1, 8'h70);
      chk("req on", req, 3'h7);
      @(posedge clk_i);
      lat <= l[3:0];
      dma_en <= 1'b1;
      repeat (40) @(posedge clk_i);
      #1;
      chk("dma req", req, 3'h0);
      rchk("dma stat", 3'h1, 8'hf8);
      @(posedge clk_i);
      dma_en <= 1'b0;
    end
    // interrupt raised, cleared, masked
    @(posedge clk_i);
    evt.a_is_capture <= 3'h0;
    wr(3'h3, 8'h07);
    wr(3'h4, 8'h02);
    ev(3'h2, 3'h0, 3'h0);
    chk("irq", irq, 1'b1);
    rchk("irq st", 3'h2, 8'h02);
    wr(3'h3, 8'h02);
    chk("irq clr", irq, 1'b0);
    wr(3'h4, 8'h00);
    ev(3'h2, 3'h0, 3'h0);
    chk("irq mask", irq, 1'b0);
    // pulse width outputs
    wr(3'h0, 8'h07);
    chk("oe", pin_oe, 3'h7);
    ev(3'h7, 3'h0, 3'h0);
    chk("pwm hi", pin, 3'h7);
    ev(3'h0, 3'h5, 3'h0);
    chk("pwm lo", pin, 3'h2);
    wr(3'h0, 8'h02);
    chk("oe one", pin_oe, 3'h2);
    chk("pin one", pin, 3'h2);
    wr(3'h0, 8'h00);
    chk("oe off", pin_oe, 3'h0);
    // phase counting; tick held high must be ignored
    @(posedge clk_i);
    start_ch2 <= 1'b1;
    wr(3'h0, 8'h40);
    @(posedge clk_i);
    tick <= 1'b1;
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h10);
    repeat (4) @(posedge clk_i);
    #1;
    chk("no tick", cnt, 16'h0010);
    foreach (up_seq[i]) ph(up_seq[i]);
    chk("up", cnt, 16'h0014);
    foreach (dn_seq[i]) ph(dn_seq[i]);
    chk("down", cnt, 16'h0010);
    wr(3'h5, 8'hff);
    wr(3'h6, 8'hff);
    ovf_cnt = 0;
    ph(2'b01);
    chk("ovf", cnt, 16'h0000);
    ph(2'b00);
    chk("udf", cnt, 16'hffff);
    chk("both", ovf_cnt, 16'h2);
    wr(3'h0, 8'h60);
    ph(2'b01);
    ph(2'b00);
    chk("ovf only", ovf_cnt, 16'h3);
    // pwm matches left all three flags up; read and clear them first
    rwchk("pre ph", 8'hff, 8'h70);
    ev(3'h4, 3'h0, 3'h0);
    chk("req ph", req, 3'h4);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("clear ph", cnt, 16'h0000);
    // normal mode counts the tick again
    wr(3'h0, 8'h00);
    v = cnt;
    repeat (4) @(posedge clk_i);
    #1;
    chk("tick", cnt, v + 16'h4);
    // clock enable low must freeze the counter while the tick keeps coming
    @(posedge clk_i);
    ce_i <= 1'b0;
    #1;
    v = cnt;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    chk("ce hold", cnt, v);
    // standby acts like reset
    wr(3'h0, 8'h67);
    wr(3'h1, 8'h70);
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    rchk("mode sby", 3'h0, 8'h98);
    rchk("stat sby", 3'h1, 8'h88);
    summarize();
  end
endmodule : tb_top
